/* File: hdl/sccg_ctrl.sv */
`timescale 1ns/1ps
module sccg_ctrl
	import sccg_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_n,
	input  wire logic [ADDR_W-1:0]    i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic      [31:0]          o_avs_readdata,
	output logic      [1:0]           o_avs_response,
	output logic                      o_avs_waitrequest,
	input  wire logic                 i_sleep_req,
	input  wire logic                 i_deep_sleep_req,
	input  wire logic [N_UNITS-1:0]   i_periph_access,
	output logic      [N_UNITS-1:0]   o_periph_fault,
	output logic      [N_UNITS-1:0]   o_unit_enable,
	output logic      [N_UNITS-1:0]   o_gated_clk,
	output logic      [2:0]           o_power_state,
	output logic                      o_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic                 ack_q;
	logic                 ack_d;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic [1:0]           resp_q;
	logic [1:0]           resp_d;

	logic                 auto_q;
	logic                 auto_d;
	logic [31:0]          run_q;
	logic [31:0]          run_d;
	logic [31:0]          sleep_q;
	logic [31:0]          sleep_d;
	logic [31:0]          deep_q;
	logic [31:0]          deep_d;
	logic [N_UNITS-1:0]   irq_en_q;
	logic [N_UNITS-1:0]   irq_en_d;
	logic [N_UNITS-1:0]   irq_st_q;
	logic [N_UNITS-1:0]   irq_st_d;
	logic                 irq_q;
	logic                 irq_d;

	sccg_pwr_type         pwr_q;
	sccg_pwr_type         pwr_d;
	logic [N_UNITS-1:0]   eff_q;
	logic [N_UNITS-1:0]   eff_d;
	logic [N_UNITS-1:0]   fault_q;
	logic [N_UNITS-1:0]   fault_d;

	logic                 req;
	logic                 wr_take;
	logic                 rd_start;
	logic                 sel_cfg;
	logic                 sel_run;
	logic                 sel_sleep;
	logic                 sel_deep;
	logic                 sel_st;
	logic                 sel_en;
	logic                 sel_clr;
	logic                 mapped;
	logic [31:0]          cfg_view;
	logic [31:0]          cfg_wr;
	logic [N_UNITS-1:0]   clr_vec;

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	always_comb begin
		req       = i_avs_read | i_avs_write;
		wr_take   = i_avs_write & ack_q;
		rd_start  = i_avs_read & ~ack_q;
		sel_cfg   = (i_avs_address == ADDR_W'(RUN_CLOCK_CONFIG_OFS));
		sel_run   = (i_avs_address == ADDR_W'(RUN_CLOCK_GATE_1_OFS));
		sel_sleep = (i_avs_address == ADDR_W'(SLEEP_CLOCK_GATE_1_OFS));
		sel_deep  = (i_avs_address == ADDR_W'(DEEP_CLOCK_GATE_1_OFS));
		sel_st    = (i_avs_address == ADDR_W'(IRQ_STATUS_OFS));
		sel_en    = (i_avs_address == ADDR_W'(IRQ_ENABLE_OFS));
		sel_clr   = (i_avs_address == ADDR_W'(IRQ_CLEAR_OFS));
		mapped    = sel_cfg | sel_run | sel_sleep | sel_deep | sel_st | sel_en | sel_clr;
		cfg_view  = '0;
		cfg_view[AUTO_CLOCK_GATING_BIT] = auto_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait state, then answer

	always_comb begin
		ack_d   = req & ~ack_q;
		rdata_d = rdata_q;
		resp_d  = resp_q;
		if (req && !ack_q) begin
			resp_d  = mapped ? RESP_OKAY : RESP_DECODEERROR;
			rdata_d = '0;
		end
		if (rd_start) begin
			case (1'b1)
				sel_cfg:   rdata_d = cfg_view;
				sel_run:   rdata_d = run_q & GATE_IMPL_MASK;
				sel_sleep: rdata_d = sleep_q & GATE_IMPL_MASK;
				sel_deep:  rdata_d = deep_q & GATE_IMPL_MASK;
				sel_st:    rdata_d = sccg_unpack(irq_st_q);
				sel_en:    rdata_d = sccg_unpack(irq_en_q);
				default:   rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
			resp_q  <= RESP_OKAY;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			resp_q  <= resp_d;
		end
	end

	assign o_avs_waitrequest = req & ~ack_q;
	assign o_avs_readdata    = rdata_q;
	assign o_avs_response    = resp_q;

	////////////////////////////////////////////////////////////////////////////////
	// software registers

	always_comb begin
		auto_d   = auto_q;
		run_d    = run_q;
		sleep_d  = sleep_q;
		deep_d   = deep_q;
		irq_en_d = irq_en_q;
		clr_vec  = '0;
		cfg_wr   = sccg_merge(cfg_view, i_avs_writedata, i_avs_byteenable);
		if (wr_take) begin
			case (1'b1)
				sel_cfg: begin
					auto_d = cfg_wr[AUTO_CLOCK_GATING_BIT];
				end
				sel_run: begin
					run_d = sccg_merge(run_q, i_avs_writedata, i_avs_byteenable) & GATE_IMPL_MASK;
				end
				sel_sleep: begin
					sleep_d = sccg_merge(sleep_q, i_avs_writedata, i_avs_byteenable) & GATE_IMPL_MASK;
				end
				sel_deep: begin
					deep_d = sccg_merge(deep_q, i_avs_writedata, i_avs_byteenable) & GATE_IMPL_MASK;
				end
				sel_en: begin
					irq_en_d = sccg_pack(sccg_merge(sccg_unpack(irq_en_q), i_avs_writedata, i_avs_byteenable));
				end
				sel_clr: begin
					clr_vec = sccg_pack(sccg_merge('0, i_avs_writedata, i_avs_byteenable));
				end
				default: begin
					clr_vec = '0;
				end
			endcase
		end
		// a fault in the clearing cycle stays set
		irq_st_d = (irq_st_q & ~clr_vec) | fault_d;
		irq_d    = |(irq_st_d & irq_en_d);
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			auto_q   <= AUTO_CLOCK_GATING_RESET;
			run_q    <= GATE_RESET;
			sleep_q  <= GATE_RESET;
			deep_q   <= GATE_RESET;
			irq_en_q <= '0;
			irq_st_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			auto_q   <= auto_d;
			run_q    <= run_d;
			sleep_q  <= sleep_d;
			deep_q   <= deep_d;
			irq_en_q <= irq_en_d;
			irq_st_q <= irq_st_d;
			irq_q    <= irq_d;
		end
	end

	assign o_irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// power state and active enable set

	always_comb begin
		pwr_d = SCCG_PWR_RUN;
		if (auto_q && i_deep_sleep_req) begin
			pwr_d = SCCG_PWR_DEEP;
		end else if (auto_q && i_sleep_req) begin
			pwr_d = SCCG_PWR_SLEEP;
		end
		case (pwr_q)
			SCCG_PWR_RUN:   eff_d = sccg_pack(run_q);
			SCCG_PWR_SLEEP: eff_d = sccg_pack(sleep_q);
			SCCG_PWR_DEEP:  eff_d = sccg_pack(deep_q);
			default:        eff_d = sccg_pack(run_q);
		endcase
		// a gated unit refuses access with a fault
		fault_d = i_periph_access & ~eff_q;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pwr_q   <= SCCG_PWR_RUN;
			eff_q   <= '0;
			fault_q <= '0;
		end else begin
			pwr_q   <= pwr_d;
			eff_q   <= eff_d;
			fault_q <= fault_d;
		end
	end

	assign o_unit_enable  = eff_q;
	assign o_periph_fault = fault_q;
	assign o_power_state  = pwr_q;

	////////////////////////////////////////////////////////////////////////////////
	// clock gates

	for (genvar g = 0; g < N_UNITS; g++) begin : gen_gate
		sccg_clk_gate u_gate (
			.i_core_clk  (i_core_clk),
			.i_rst_n     (i_rst_n),
			.i_enable    (eff_q[g]),
			.o_gated_clk (o_gated_clk[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_core_clk);
	endclocking

	default disable iff (!i_rst_n);

	rsv_bits_zero_a: assert property (
		((run_q | sleep_q | deep_q) & ~GATE_IMPL_MASK) == 32'h0000_0000
	) else $error("reserved gating bits not zero");

	reset_clear_a: assert property (
		$rose(i_rst_n) |-> (run_q == GATE_RESET && sleep_q == GATE_RESET
			&& deep_q == GATE_RESET && eff_q == '0 && o_unit_enable == '0)
	) else $error("gating state not cleared by reset");

	bus_wait_a: assert property (
		(req && !ack_q) |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest)
	) else $error("answer not given after one wait state");

	sleep_write_a: assert property (
		(i_avs_write && !o_avs_waitrequest && sel_sleep && i_avs_byteenable == 4'hf)
			|=> sleep_q == ($past(i_avs_writedata) & GATE_IMPL_MASK)
	) else $error("sleep gating write lost");

	deep_write_a: assert property (
		(i_avs_write && !o_avs_waitrequest && sel_deep && i_avs_byteenable == 4'hf)
			|=> deep_q == ($past(i_avs_writedata) & GATE_IMPL_MASK)
	) else $error("deep-sleep gating write lost");

	gated_fault_a: assert property (
		(i_periph_access != '0) |=> o_periph_fault == $past(i_periph_access & ~eff_q)
	) else $error("fault not matched to gated access");

	state_select_a: assert property (
		(pwr_q == SCCG_PWR_DEEP) |=> o_unit_enable == sccg_pack($past(deep_q))
	) else $error("deep-sleep enables not applied");

	auto_gate_a: assert property (
		(!auto_q) |=> pwr_q == SCCG_PWR_RUN ##1 o_unit_enable == sccg_pack($past(run_q))
	) else $error("low-power gating used without auto gating");

	sticky_status_a: assert property (
		1'b1 |=> (irq_st_q & $past(irq_st_q & ~clr_vec)) == $past(irq_st_q & ~clr_vec)
	) else $error("status flag lost or cleared wrongly");

	unmapped_resp_a: assert property (
		(req && !mapped && !o_avs_waitrequest) |-> o_avs_response == RESP_DECODEERROR
	) else $error("unmapped access not refused");

	run_write_a: assert property (
		(i_avs_write && !o_avs_waitrequest && sel_run && i_avs_byteenable == 4'hf)
			|=> run_q == ($past(i_avs_writedata) & GATE_IMPL_MASK)
	) else $error("run gating write lost");

	rsv_read_zero_a: assert property (
		(i_avs_read && !o_avs_waitrequest && (sel_run || sel_sleep || sel_deep))
			|-> (o_avs_readdata & ~GATE_IMPL_MASK) == 32'h0000_0000
	) else $error("reserved gating bits read nonzero");

	sleep_readback_a: assert property (
		(i_avs_read && !o_avs_waitrequest && sel_sleep) |-> o_avs_readdata == sleep_q
	) else $error("sleep gating readback wrong");

	deep_readback_a: assert property (
		(i_avs_read && !o_avs_waitrequest && sel_deep) |-> o_avs_readdata == deep_q
	) else $error("deep-sleep gating readback wrong");

	cfg_readback_a: assert property (
		(i_avs_read && !o_avs_waitrequest && sel_cfg) |-> o_avs_readdata == cfg_view
	) else $error("auto gating readback wrong");

	unmapped_write_a: assert property (
		(i_avs_write && !mapped) |=> $stable(run_q) && $stable(sleep_q) && $stable(deep_q) && $stable(auto_q)
	) else $error("unmapped write changed a register");

	run_apply_a: assert property (
		(pwr_q == SCCG_PWR_RUN) |=> o_unit_enable == sccg_pack($past(run_q))
	) else $error("run enables not applied");

	sleep_apply_a: assert property (
		(pwr_q == SCCG_PWR_SLEEP) |=> o_unit_enable == sccg_pack($past(sleep_q))
	) else $error("sleep enables not applied");

	deep_enter_a: assert property (
		(auto_q && i_deep_sleep_req) |=> pwr_q == SCCG_PWR_DEEP
	) else $error("deep-sleep state not entered");

	sleep_enter_a: assert property (
		(auto_q && i_sleep_req && !i_deep_sleep_req) |=> pwr_q == SCCG_PWR_SLEEP
	) else $error("sleep state not entered");

	power_onehot_a: assert property (
		$onehot(pwr_q)
	) else $error("power state not one-hot");

	fault_status_a: assert property (
		(o_periph_fault & ~irq_st_q) == '0
	) else $error("fault shown without status flag");

	irq_level_a: assert property (
		o_irq == |(irq_st_q & irq_en_q)
	) else $error("interrupt level does not match status");

endmodule

/* File: hdl/sccg_pkg.sv */
// Overview of operation
// - timer enable bits 18, 17, 16 gate timers 2, 1, 0, read-write.
// - bit 12 is a read-write enable gating the first two-wire module clock.
// - bit 4 is a read-write enable gating the synchronous serial module clock.
// - bits 1 and 0 are read-write enables gating second and first UART clocks.
// - set bit clocks and enables its unit; clear bit stops clock, holds disabled.
// - access to a unit whose clock is gated off answers with a bus fault.
// - all implemented enable bits read zero after reset.
// - bits 15:13, 11:5 and 3:2 read zero and ignore writes.
// - run, sleep and deep-sleep registers apply in their matching power states.
// - sleep registers take effect only while automatic clock gating is set.
// - deep-sleep gating register is decoded at offset 0x124.
// - sleep gating register is decoded at offset 0x114.
package sccg_pkg;

	localparam int unsigned N_UNITS                 = 7;

	// byte offsets of the register file
	localparam logic [11:0] RUN_CLOCK_CONFIG_OFS    = 12'h060;
	localparam logic [11:0] RUN_CLOCK_GATE_1_OFS    = 12'h104;
	localparam logic [11:0] SLEEP_CLOCK_GATE_1_OFS  = 12'h114;
	localparam logic [11:0] DEEP_CLOCK_GATE_1_OFS   = 12'h124;
	localparam logic [11:0] IRQ_STATUS_OFS          = 12'h180;
	localparam logic [11:0] IRQ_ENABLE_OFS          = 12'h184;
	localparam logic [11:0] IRQ_CLEAR_OFS           = 12'h188;

	// field positions inside the gating registers and the run clock config register
	localparam int unsigned ASYNC_SERIAL0_BIT       = 0;
	localparam int unsigned ASYNC_SERIAL1_BIT       = 1;
	localparam int unsigned SYNC_SERIAL0_BIT        = 4;
	localparam int unsigned TWO_WIRE0_BIT           = 12;
	localparam int unsigned GP_COUNTER0_BIT         = 16;
	localparam int unsigned GP_COUNTER1_BIT         = 17;
	localparam int unsigned GP_COUNTER2_BIT         = 18;
	localparam int unsigned AUTO_CLOCK_GATING_BIT   = 27;

	localparam int unsigned UNIT_POS [0:N_UNITS-1]  = '{ASYNC_SERIAL0_BIT, ASYNC_SERIAL1_BIT,
		SYNC_SERIAL0_BIT, TWO_WIRE0_BIT, GP_COUNTER0_BIT, GP_COUNTER1_BIT, GP_COUNTER2_BIT};

	localparam logic [31:0] GATE_IMPL_MASK          = 32'h0007_1013;
	localparam logic [31:0] GATE_RESET              = 32'h0000_0000;
	localparam logic        AUTO_CLOCK_GATING_RESET = 1'b0;

	// avalon response codes
	localparam logic [1:0]  RESP_OKAY               = 2'h0;
	localparam logic [1:0]  RESP_DECODEERROR        = 2'h3;

	// wait states inserted before every answer
	localparam int unsigned BUS_WAIT_CYCLES         = 1;

	typedef enum logic [2:0] {
		SCCG_PWR_RUN   = 3'h1,
		SCCG_PWR_SLEEP = 3'h2,
		SCCG_PWR_DEEP  = 3'h4
	} sccg_pwr_type;

	// register layout to per-unit vector
	function automatic logic [N_UNITS-1:0] sccg_pack(input logic [31:0] r);
		logic [N_UNITS-1:0] v;
		v = '0;
		for (int i = 0; i < N_UNITS; i++) begin
			v[i] = r[UNIT_POS[i]];
		end
		return v;
	endfunction

	// per-unit vector to register layout
	function automatic logic [31:0] sccg_unpack(input logic [N_UNITS-1:0] v);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < N_UNITS; i++) begin
			r[UNIT_POS[i]] = v[i];
		end
		return r;
	endfunction

	// byte-lane merge of a write
	function automatic logic [31:0] sccg_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

/* File: hdl/sccg_clk_gate.sv */
`timescale 1ns/1ps
module sccg_clk_gate (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_enable,
	output logic      o_gated_clk
);

	logic en_neg_q;
	logic en_neg_d;

	always_comb begin
		en_neg_d = i_enable;
	end

	// enable moves only while the clock is low, so no pulse is cut
	always_ff @(negedge i_core_clk) begin
		if (!i_rst_n) begin
			en_neg_q <= 1'b0;
		end else begin
			en_neg_q <= en_neg_d;
		end
	end

	assign o_gated_clk = i_core_clk & en_neg_q;

endmodule

/* File: bench/sccg_ctrl_tb.sv */
`timescale 1ns/1ps
module sccg_ctrl_tb;
	import sccg_pkg::*;

	localparam logic [11:0] ADDRS [8] = '{RUN_CLOCK_GATE_1_OFS, SLEEP_CLOCK_GATE_1_OFS, DEEP_CLOCK_GATE_1_OFS,
		RUN_CLOCK_CONFIG_OFS, IRQ_STATUS_OFS, IRQ_ENABLE_OFS, IRQ_CLEAR_OFS, 12'h200};

	logic               clk;
	logic               rst_n;
	logic [11:0]        addr;
	logic               rd;
	logic               wr;
	logic [31:0]        wdata;
	logic [3:0]         be;
	logic [31:0]        rdata;
	logic [1:0]         resp;
	logic               wait_req;
	logic               slp_req;
	logic               deep_req;
	logic [N_UNITS-1:0] access;
	logic [N_UNITS-1:0] fault;
	logic [N_UNITS-1:0] unit_en;
	logic [N_UNITS-1:0] gclk;
	logic [2:0]         pwr;
	logic               irq;
	int                 miscompares;
	int                 checks_done;
	int                 cycles = 0;
	logic [31:0]        seed;
	logic [31:0]        gate_m [3];
	logic [31:0]        sts_m;
	logic [31:0]        ien_m;
	logic               auto_m;
	logic [31:0]        got;
	logic [1:0]         got_resp;

	sccg_ctrl sccg_ctrl_inst (
		.i_core_clk        (clk),
		.i_rst_n           (rst_n),
		.i_avs_address     (addr),
		.i_avs_read        (rd),
		.i_avs_write       (wr),
		.i_avs_writedata   (wdata),
		.i_avs_byteenable  (be),
		.o_avs_readdata    (rdata),
		.o_avs_response    (resp),
		.o_avs_waitrequest (wait_req),
		.i_sleep_req       (slp_req),
		.i_deep_sleep_req  (deep_req),
		.i_periph_access   (access),
		.o_periph_fault    (fault),
		.o_unit_enable     (unit_en),
		.o_gated_clk       (gclk),
		.o_power_state     (pwr),
		.o_irq             (irq)
	);

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		return (o & ~m) | (d & m);
	endfunction

	function automatic logic [N_UNITS-1:0] units(input logic [31:0] r);
		logic [N_UNITS-1:0] u;
		for (int i = 0; i < N_UNITS; i++) begin
			u[i] = r[UNIT_POS[i]];
		end
		return u;
	endfunction

	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		case (a)
			RUN_CLOCK_GATE_1_OFS:   return gate_m[0];
			SLEEP_CLOCK_GATE_1_OFS: return gate_m[1];
			DEEP_CLOCK_GATE_1_OFS:  return gate_m[2];
			RUN_CLOCK_CONFIG_OFS:   return {4'h0, auto_m, 27'h0};
			IRQ_STATUS_OFS:         return sts_m;
			IRQ_ENABLE_OFS:         return ien_m;
			default:                return 32'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		be <= b;
		// hold the request until waitrequest is seen low at a rising edge
		do begin
			@(posedge clk);
		end while (wait_req !== 1'b0);
		got = rdata;
		got_resp = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		bus(1'b1, a, d, b);
		case (a)
			RUN_CLOCK_GATE_1_OFS:   gate_m[0] = lanes(gate_m[0], d, b) & 32'h0007_1013;
			SLEEP_CLOCK_GATE_1_OFS: gate_m[1] = lanes(gate_m[1], d, b) & 32'h0007_1013;
			DEEP_CLOCK_GATE_1_OFS:  gate_m[2] = lanes(gate_m[2], d, b) & 32'h0007_1013;
			RUN_CLOCK_CONFIG_OFS:   auto_m = b[3] ? d[27] : auto_m;
			IRQ_ENABLE_OFS:         ien_m = lanes(ien_m, d, b) & 32'h0007_1013;
			IRQ_CLEAR_OFS:          sts_m = sts_m & ~lanes(32'h0, d, b);
			default:                ;
		endcase
	endtask

	task automatic rd_chk(input logic [11:0] a);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(got, exp_rd(a));
		chk({30'h0, got_resp}, (a == 12'h200) ? 32'h3 : 32'h0);
	endtask

	task automatic settle_chk(input logic [31:0] g);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({25'h0, unit_en}, {25'h0, units(g)});
		@(posedge clk);
		#1 chk({25'h0, gclk}, {25'h0, units(g)});
		@(negedge clk);
		#1 chk({25'h0, gclk}, 32'h0);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
	end

	initial begin
		rst_n = 1'b0;
		{addr, rd, wr, wdata, be, slp_req, deep_req, access} = '0;
		{miscompares, checks_done} = '0;
		seed = 32'h1eb11180;
		gate_m = '{default: 32'h0};
		{sts_m, ien_m, auto_m} = '0;
		// watchdog: a hang counts as a mismatch
		fork
			begin
				wait (cycles >= 20000);
				miscompares++;
				print_verdict();
			end
		join_none
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd_chk(ADDRS[i]);
		end
		for (int i = 0; i < 3; i++) begin
			wr_reg(ADDRS[i], 32'hffff_ffff, 4'hf);
			bus(1'b0, ADDRS[i], 32'h0, 4'hf);
			chk(got, 32'h0007_1013);
		end
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			wr_reg(ADDRS[seed[2:0]], xs(seed), seed[7:4]);
			rd_chk(ADDRS[seed[2:0]]);
		end
		wr_reg(RUN_CLOCK_CONFIG_OFS, 32'h0, 4'hf);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			bus(1'b0, RUN_CLOCK_GATE_1_OFS, 32'h0, 4'hf);
			chk(got, gate_m[0]);
			wr_reg(RUN_CLOCK_GATE_1_OFS, (got & ~32'h0007_1013) | (seed & 32'h0007_1013), 4'hf);
			settle_chk(gate_m[0]);
		end
		wr_reg(IRQ_ENABLE_OFS, 32'h0, 4'hf);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			@(posedge clk);
			access <= seed[6:0];
			@(posedge clk);
			access <= '0;
			@(negedge clk);
			chk({25'h0, fault}, {25'h0, seed[6:0] & ~units(gate_m[0])});
			for (int k = 0; k < N_UNITS; k++) begin
				sts_m[UNIT_POS[k]] |= seed[k] & ~gate_m[0][UNIT_POS[k]];
			end
			chk({31'h0, irq}, 32'h0);
		end
		rd_chk(IRQ_STATUS_OFS);
		wr_reg(IRQ_ENABLE_OFS, 32'hffff_ffff, 4'hf);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, |sts_m});
		wr_reg(IRQ_CLEAR_OFS, 32'hffff_ffff, 4'hf);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		rd_chk(IRQ_STATUS_OFS);
		@(posedge clk);
		slp_req <= 1'b1;
		settle_chk(gate_m[0]);
		chk({29'h0, pwr}, 32'h1);
		wr_reg(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000, 4'hf);
		settle_chk(gate_m[1]);
		chk({29'h0, pwr}, 32'h2);
		@(posedge clk);
		deep_req <= 1'b1;
		settle_chk(gate_m[2]);
		chk({29'h0, pwr}, 32'h4);
		@(posedge clk);
		slp_req <= 1'b0;
		deep_req <= 1'b0;
		settle_chk(gate_m[0]);
		chk({29'h0, pwr}, 32'h1);
		print_verdict();
	end
endmodule
